// ### gpm_defines.vh
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

// ==========================================
// register indices (byte address is four times the index)
`define GPM_IDX_P0_DATA 8'h80
`define GPM_IDX_P1_DATA 8'h90
`define GPM_IDX_P2_DATA 8'ha0
`define GPM_IDX_P3_DATA 8'hb0
`define GPM_IDX_P0_MODE_A 8'h96
`define GPM_IDX_P0_MODE_B 8'h97
`define GPM_IDX_P1_MODE_A 8'h9e
`define GPM_IDX_P1_MODE_B 8'h9f
`define GPM_IDX_P2_MODE_A 8'ha6
`define GPM_IDX_P2_MODE_B 8'ha7
`define GPM_IDX_P3_MODE_A 8'hbe
`define GPM_IDX_P3_MODE_B 8'hbf

// ==========================================
// implemented pin masks per port
`define GPM_MASK_P0 8'h60
`define GPM_MASK_P1 8'hcf
`define GPM_MASK_P2 8'h7f
`define GPM_MASK_P3 8'h0f

// ==========================================
// reset values
`define GPM_RST_DATA 8'hff
`define GPM_RST_MODE_A 8'hff
`define GPM_RST_MODE_B 8'h00

// ==========================================
// pin modes, {b, a}
`define GPM_MODE_OPEN_DRAIN 2'h0
`define GPM_MODE_QUASI 2'h1
`define GPM_MODE_HIGH_IMPEDANCE 2'h2
`define GPM_MODE_PUSH_PULL 2'h3

// ==========================================
// timing and bus
`define GPM_QUASI_BOOST 2'h2
`define GPM_HTRANS_NONSEQ_BIT 1

`endif

// ### gpm_sync.v
`timescale 1ns/1ns

// ==========================================
// two-stage level synchroniser
module gpm_sync
(
	input wire hclk,
	input wire hresetn,
	input wire [31:0] d,
	output wire [31:0] q
);
	reg [31:0] meta_reg;
	reg [31:0] sync_reg;

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta_reg <= 32'hffffffff;
			sync_reg <= 32'hffffffff;
		end
		else
		begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule // gpm_sync

// ### gpm_pin.v
`timescale 1ns/1ns
`include "gpm_defines.vh"

// ==========================================
// one pin driver: mode and latch to drive, enable, pull-up
module gpm_pin
(
	input wire hclk,
	input wire hresetn,
	input wire latch,
	input wire [1:0] mode,
	output wire pin_out,
	output wire pin_oe,
	output wire pin_pullup
);
	reg out_reg;
	reg oe_reg;
	reg pu_reg;
	reg latch_prev_reg;
	reg [1:0] boost_reg;
	reg out_next;
	reg oe_next;
	reg pu_next;
	reg [1:0] boost_next;

	always @*
	begin
		out_next = 1'b0;
		oe_next = 1'b0;
		pu_next = 1'b0;
		boost_next = 2'h0;
		case (mode)
		`GPM_MODE_OPEN_DRAIN:
		begin
			out_next = 1'b0;
			oe_next = ~latch;
		end
		`GPM_MODE_QUASI:
		begin
			// short strong high speeds the rising edge past the weak pull-up
			if (latch && !latch_prev_reg)
				boost_next = `GPM_QUASI_BOOST;
			else if (boost_reg != 2'h0)
				boost_next = boost_reg - 2'h1;
			out_next = latch;
			oe_next = ~latch | (boost_next != 2'h0);
			pu_next = latch;
		end
		`GPM_MODE_HIGH_IMPEDANCE:
		begin
			oe_next = 1'b0;
		end
		`GPM_MODE_PUSH_PULL:
		begin
			out_next = latch;
			oe_next = 1'b1;
		end
		default:
		begin
			oe_next = 1'b0;
		end
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_reg <= 1'b1;
			oe_reg <= 1'b0;
			pu_reg <= 1'b1;
			latch_prev_reg <= 1'b1;
			boost_reg <= 2'h0;
		end
		else
		begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			pu_reg <= pu_next;
			latch_prev_reg <= latch;
			boost_reg <= boost_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign pin_pullup = pu_reg;
endmodule // gpm_pin

// ### gpm_top.v
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "gpm_defines.vh"

// Functional notes
// [RQ1] pin mode is {b,a}: 00 open drain, 01 quasi, 10 high-z, 11 push-pull
// [RQ2] port0 data has only bits 6 and 5, resets to all ones
// [RQ3] port1 data bits 7,6,3..0 reach pins, 5 and 4 reserved, resets ones
// [RQ4] port2 data bits 6..0 reach pins, bit 7 reserved, resets ones
// [RQ5] port3 data bits 3..0 reach pins, upper nibble reserved, resets ones
// [RQ6] port0 mode a holds only pins 6 and 5, resets ones
// [RQ7] port0 mode b holds only pins 6 and 5, resets zeros: quasi start
// [RQ8] port1 mode a holds pins 7,6,3..0, resets ones
// [RQ9] port1 mode b holds pins 7,6,3..0, resets zeros
// [RQ10] ports 2 and 3 have mode a/b pairs, same coding and resets
// [RQ11] data reads return pin levels; reserved bits ignore writes
module gpm_top
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	input wire [7:0] port0_pin_in,
	output wire [7:0] port0_pin_out,
	output wire [7:0] port0_pin_oe,
	output wire [7:0] port0_pin_pullup,
	input wire [7:0] port1_pin_in,
	output wire [7:0] port1_pin_out,
	output wire [7:0] port1_pin_oe,
	output wire [7:0] port1_pin_pullup,
	input wire [7:0] port2_pin_in,
	output wire [7:0] port2_pin_out,
	output wire [7:0] port2_pin_oe,
	output wire [7:0] port2_pin_pullup,
	input wire [7:0] port3_pin_in,
	output wire [7:0] port3_pin_out,
	output wire [7:0] port3_pin_oe,
	output wire [7:0] port3_pin_pullup
);
	// ==========================================
	// per-port constant tables, port n in bits n*8+7..n*8
	localparam [31:0] IDX_DATA = {`GPM_IDX_P3_DATA, `GPM_IDX_P2_DATA,
		`GPM_IDX_P1_DATA, `GPM_IDX_P0_DATA};
	localparam [31:0] IDX_MODE_A = {`GPM_IDX_P3_MODE_A, `GPM_IDX_P2_MODE_A,
		`GPM_IDX_P1_MODE_A, `GPM_IDX_P0_MODE_A};
	localparam [31:0] IDX_MODE_B = {`GPM_IDX_P3_MODE_B, `GPM_IDX_P2_MODE_B,
		`GPM_IDX_P1_MODE_B, `GPM_IDX_P0_MODE_B};
	localparam [31:0] PIN_MASK = {`GPM_MASK_P3, `GPM_MASK_P2,
		`GPM_MASK_P1, `GPM_MASK_P0};

	// ==========================================
	// data-phase states
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WRITE = 2'h1;
	localparam [1:0] ST_RD_WAIT = 2'h2;
	localparam [1:0] ST_RD_DONE = 2'h3;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [7:0] idx_reg;
	reg [31:0] hrdata_reg;
	wire accept;
	wire wr_commit;
	wire ld_rdata;
	wire [31:0] pin_in_all;
	wire [31:0] pin_sync;
	wire [31:0] latch_all;
	wire [31:0] mode_a_all;
	wire [31:0] mode_b_all;
	wire [31:0] drv_out;
	wire [31:0] drv_oe;
	wire [31:0] drv_pu;
	wire [39:0] rd_chain;

	// ==========================================
	// ahb-lite slave
	assign accept = hsel & htrans[`GPM_HTRANS_NONSEQ_BIT] & hready;
	assign wr_commit = (state_reg == ST_WRITE);
	assign ld_rdata = (state_reg == ST_RD_WAIT);
	// one wait state on reads so read data come from a flip-flop
	assign hreadyout = (state_reg != ST_RD_WAIT);
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always @*
	begin
		state_next = ST_IDLE;
		case (state_reg)
		ST_RD_WAIT:
			state_next = ST_RD_DONE;
		ST_IDLE, ST_WRITE, ST_RD_DONE:
		begin
			if (accept)
				state_next = hwrite ? ST_WRITE : ST_RD_WAIT;
			else
				state_next = ST_IDLE;
		end
		default:
			state_next = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= ST_IDLE;
			idx_reg <= 8'h00;
			hrdata_reg <= 32'h00000000;
		end
		else
		begin
			state_reg <= state_next;
			// misaligned addresses decode to no register
			if (accept)
				idx_reg <= (haddr[1:0] == 2'h0) ? haddr[9:2] : 8'h00;
			if (ld_rdata)
				hrdata_reg <= {24'h000000, rd_chain[39:32]};
		end
	end

	// ==========================================
	// pin input synchroniser
	assign pin_in_all = {port3_pin_in, port2_pin_in, port1_pin_in,
		port0_pin_in};

	gpm_sync u_sync
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.d(pin_in_all),
		.q(pin_sync)
	);

	// ==========================================
	// per-port registers and read mux
	assign rd_chain[7:0] = 8'h00;

	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1)
		begin : g_port
			localparam [7:0] MASK = PIN_MASK[p*8+:8];
			localparam [7:0] I_DATA = IDX_DATA[p*8+:8];
			localparam [7:0] I_A = IDX_MODE_A[p*8+:8];
			localparam [7:0] I_B = IDX_MODE_B[p*8+:8];
			reg [7:0] latch_reg;
			reg [7:0] mode_a_reg;
			reg [7:0] mode_b_reg;
			wire [7:0] rd_val;

			always @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					// [RQ2] [RQ3] [RQ4] [RQ5] latch reset ones
					latch_reg <= `GPM_RST_DATA;
					// [RQ6] [RQ8] [RQ10] mode a ones
					mode_a_reg <= `GPM_RST_MODE_A;
					// [RQ7] [RQ9] [RQ10] mode b zeros
					mode_b_reg <= `GPM_RST_MODE_B;
				end
				else if (wr_commit)
				begin
					// [RQ11] reserved bits keep
					if (idx_reg == I_DATA)
						latch_reg <= (latch_reg & ~MASK) | (hwdata[7:0] & MASK);
					// [RQ6] [RQ8] [RQ10] implemented bits only
					if (idx_reg == I_A)
						mode_a_reg <= (mode_a_reg & ~MASK) | (hwdata[7:0] & MASK);
					// [RQ7] [RQ9] [RQ10] implemented bits only
					if (idx_reg == I_B)
						mode_b_reg <= (mode_b_reg & ~MASK) | (hwdata[7:0] & MASK);
				end
			end

			// [RQ11] read pin levels
			assign rd_val = (idx_reg == I_DATA) ? (pin_sync[p*8+:8] & MASK) :
				(idx_reg == I_A) ? (mode_a_reg & MASK) :
				(idx_reg == I_B) ? (mode_b_reg & MASK) : 8'h00;
			assign rd_chain[(p+1)*8+:8] = rd_chain[p*8+:8] | rd_val;
			assign latch_all[p*8+:8] = latch_reg;
			assign mode_a_all[p*8+:8] = mode_a_reg;
			assign mode_b_all[p*8+:8] = mode_b_reg;
		end
	endgenerate

	// ==========================================
	// pin drivers
	genvar b;
	generate
		for (b = 0; b < 32; b = b + 1)
		begin : g_pin
			wire drv_oe_raw;
			wire drv_pu_raw;

			// [RQ1] mode from b,a pair
			gpm_pin u_pin
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.latch(latch_all[b]),
				.mode({mode_b_all[b], mode_a_all[b]}),
				.pin_out(drv_out[b]),
				.pin_oe(drv_oe_raw),
				.pin_pullup(drv_pu_raw)
			);

			// [RQ2] [RQ3] [RQ4] [RQ5] reserved pins never drive
			assign drv_oe[b] = drv_oe_raw & PIN_MASK[b];
			assign drv_pu[b] = drv_pu_raw & PIN_MASK[b];
		end
	endgenerate

	assign port0_pin_out = drv_out[7:0] & `GPM_MASK_P0;
	assign port1_pin_out = drv_out[15:8] & `GPM_MASK_P1;
	assign port2_pin_out = drv_out[23:16] & `GPM_MASK_P2;
	assign port3_pin_out = drv_out[31:24] & `GPM_MASK_P3;
	assign port0_pin_oe = drv_oe[7:0];
	assign port1_pin_oe = drv_oe[15:8];
	assign port2_pin_oe = drv_oe[23:16];
	assign port3_pin_oe = drv_oe[31:24];
	assign port0_pin_pullup = drv_pu[7:0];
	assign port1_pin_pullup = drv_pu[15:8];
	assign port2_pin_pullup = drv_pu[23:16];
	assign port3_pin_pullup = drv_pu[31:24];
endmodule // gpm_top

// ### gpm_chk_sva.sv
`timescale 1ns/1ns
// ==========
// bus and pin checks
module gpm_chk
(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire [7:0] port0_pin_out,
	input wire [7:0] port0_pin_oe,
	input wire [7:0] port0_pin_pullup,
	input wire [7:0] port1_pin_oe,
	input wire [7:0] port3_pin_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take = hsel && htrans[1] && hready;
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_rdata_hold: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data moved");
	a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_p0_reserved: assert property (((port0_pin_oe | port0_pin_out) & 8'h9f) == 8'h0)
		else $error("port0 reserved pin active");
	a_p1_reserved: assert property ((port1_pin_oe & 8'h30) == 8'h0)
		else $error("port1 reserved pin driven");
	a_p3_reserved: assert property (port3_pin_oe[7:4] == 4'h0)
		else $error("port3 reserved pin driven");
	a_p0_quasi_start: assert property ($rose(hresetn) |-> port0_pin_pullup == 8'h60 && port0_pin_oe == 8'h0)
		else $error("port0 not quasi after reset");
endmodule // gpm_chk

bind gpm_top gpm_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .port0_pin_out(port0_pin_out),
	.port0_pin_oe(port0_pin_oe), .port0_pin_pullup(port0_pin_pullup),
	.port1_pin_oe(port1_pin_oe), .port3_pin_oe(port3_pin_oe));

// ### gpm_board.sv
`timescale 1ns/1ns
// ==========
// board wiring on one port
module gpm_board
(
	input wire hclk,
	input wire [7:0] oe,
	input wire [7:0] out,
	input wire [7:0] pu_on,
	input wire [7:0] ext_en,
	input wire [7:0] ext_val,
	output wire [7:0] level
);
	// floating pins wander so a stale value never passes
	logic [7:0] flt = 8'h00;
	always @(posedge hclk)
		flt <= ~flt;
	assign level = (oe & out) | (~oe & ext_en & ext_val)
		| (~oe & ~ext_en & (pu_on | flt));
endmodule // gpm_board

// ### tb_top.sv
`timescale 1ns/1ns
`include "gpm_defines.vh"
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe, port0_pin_pullup;
	logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe, port1_pin_pullup;
	logic [7:0] port2_pin_in, port2_pin_out, port2_pin_oe, port2_pin_pullup;
	logic [7:0] port3_pin_in, port3_pin_out, port3_pin_oe, port3_pin_pullup;
	logic [7:0] ext_en, ext_val, rd;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	wire hready = hreadyout;
	wire [2:0] hsize = 3'h2;
	logic [7:0] idx_d [4] = '{`GPM_IDX_P0_DATA, `GPM_IDX_P1_DATA,
		`GPM_IDX_P2_DATA, `GPM_IDX_P3_DATA};
	logic [7:0] idx_a [4] = '{`GPM_IDX_P0_MODE_A, `GPM_IDX_P1_MODE_A,
		`GPM_IDX_P2_MODE_A, `GPM_IDX_P3_MODE_A};
	logic [7:0] idx_b [4] = '{`GPM_IDX_P0_MODE_B, `GPM_IDX_P1_MODE_B,
		`GPM_IDX_P2_MODE_B, `GPM_IDX_P3_MODE_B};
	logic [7:0] msk [4] = '{`GPM_MASK_P0, `GPM_MASK_P1, `GPM_MASK_P2,
		`GPM_MASK_P3};

	gpm_top dut_u (.*);
	gpm_board brd0 (.hclk(hclk), .oe(port0_pin_oe), .out(port0_pin_out),
		.pu_on(port0_pin_pullup), .ext_en(8'h00), .ext_val(8'h00),
		.level(port0_pin_in));
	gpm_board brd1 (.hclk(hclk), .oe(port1_pin_oe), .out(port1_pin_out),
		.pu_on(port1_pin_pullup), .ext_en(8'h00), .ext_val(8'h00),
		.level(port1_pin_in));
	gpm_board brd2 (.hclk(hclk), .oe(port2_pin_oe), .out(port2_pin_out),
		.pu_on(port2_pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
		.level(port2_pin_in));
	gpm_board brd3 (.hclk(hclk), .oe(port3_pin_oe), .out(port3_pin_out),
		.pu_on(port3_pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
		.level(port3_pin_in));

	// ==========
	// bus tasks
	task chk(input [31:0] seen, input [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task xfer(input wr, input [7:0] idx, input [7:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata[7:0];
	endtask

	task stop_test;
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end

	// hang guard, far above the normal run
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			error_cnt++;
			stop_test;
		end
	end

	// ==========
	// tests
	initial
	begin
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		ext_en = 8'h00;
		ext_val = 8'h00;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		for (int p = 0; p < 4; p++)
		begin
			xfer(1'h0, idx_d[p], 8'h00);
			chk(rd, msk[p]);
			xfer(1'h0, idx_a[p], 8'h00);
			chk(rd, msk[p]);
			xfer(1'h0, idx_b[p], 8'h00);
			chk(rd, 8'h00);
			xfer(1'h1, idx_a[p], 8'hff);
			xfer(1'h1, idx_b[p], 8'hff);
			xfer(1'h0, idx_b[p], 8'h00);
			chk(rd, msk[p]);
			xfer(1'h1, idx_d[p], 8'h00);
			repeat (4) @(posedge hclk);
			xfer(1'h0, idx_d[p], 8'h00);
			chk(rd, 8'h00);
		end
		ext_en <= 8'hff;
		ext_val <= 8'h2a;
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'h1, `GPM_IDX_P2_DATA, 8'h00);
			xfer(1'h1, `GPM_IDX_P2_MODE_B, {8{m[1]}});
			xfer(1'h1, `GPM_IDX_P2_MODE_A, {8{m[0]}});
			repeat (4) @(posedge hclk);
			chk(port2_pin_oe, (m == 2) ? 8'h00 : 8'h7f);
			xfer(1'h1, `GPM_IDX_P2_DATA, 8'hff);
			repeat (4) @(posedge hclk);
			chk(port2_pin_oe, (m == 3) ? 8'h7f : 8'h00);
			chk(port2_pin_pullup, (m == 1) ? 8'h7f : 8'h00);
			xfer(1'h0, `GPM_IDX_P2_DATA, 8'h00);
			chk(rd, (m == 3) ? 8'h7f : 8'h2a);
		end
		xfer(1'h1, 8'h81, 8'hff);
		xfer(1'h0, 8'h81, 8'h00);
		chk(rd, 8'h00);
		stop_test;
	end
endmodule // tb_top
